// ===== include/fsr_pkg.sv
// package with constants and types used by the flash controller block
package fsr_pkg;
  // ************************************************
  // software register map
  // ************************************************
  localparam logic [3:0] FSR_CTRL_OFS = 4'h0;
  localparam logic [3:0] FSR_STAT_OFS = 4'h4;
  localparam logic [3:0] FSR_RESULT_OFS = 4'h8;
  localparam logic [3:0] FSR_RAW_OFS = 4'hc;
  localparam int FSR_CMD_RESET_BIT = 0;
  localparam int FSR_CMD_CLEAR_BIT = 1;
  localparam int FSR_CMD_STATUS_BIT = 2;
  localparam int FSR_CMD_CHECK_BIT = 3;
  localparam int FSR_CMD_X8_BIT = 4;
  localparam int FSR_CMD_DIE_BIT = 5;
  // ************************************************
  // flash commands and addresses
  // ************************************************
  localparam logic [26:0] FSR_ADR_555 = 27'h0000555;
  localparam logic [26:0] FSR_ADR_AAA = 27'h0000aaa;
  localparam logic [26:0] FSR_ADR_P1_X16 = 27'h2aaaa55;
  localparam logic [26:0] FSR_ADR_P2_X16 = 27'h15555aa;
  localparam logic [26:0] FSR_ADR_P1_X8 = 27'h55554ab;
  localparam logic [26:0] FSR_ADR_P2_X8 = 27'h2aaab54;
  localparam logic [15:0] FSR_DAT_P1 = 16'hff00;
  localparam logic [15:0] FSR_DAT_P2 = 16'h00ff;
  // byte mode carries the pattern on the low byte only
  localparam logic [15:0] FSR_DAT_P1_X8 = 16'h00ff;
  localparam logic [15:0] FSR_DAT_P2_X8 = 16'h0000;
  localparam logic [15:0] FSR_CMD_RESET = 16'h00f0;
  localparam logic [15:0] FSR_CMD_CLEAR = 16'h0071;
  localparam logic [15:0] FSR_CMD_STATUS = 16'h0070;
  localparam int FSR_DIE_BIT = 26;
  // ************************************************
  // status bit positions
  // ************************************************
  localparam int FSR_READY_BIT = 7;
  localparam int FSR_CONT_BIT = 0;
  localparam logic [7:0] FSR_STATUS_MASK = 8'hff;
  // ************************************************
  // bus timing in system clock cycles
  // ************************************************
  localparam int FSR_CLK_MHZ = 250;
  localparam int FSR_T_SETUP_NS = 10;
  localparam int FSR_T_WP_NS = 35;
  localparam int FSR_T_WEH_NS = 20;
  localparam int FSR_T_ACC_NS = 110;
  localparam int FSR_T_OEH_NS = 20;
  localparam logic [5:0] FSR_SETUP_CYC = 6'((FSR_T_SETUP_NS * FSR_CLK_MHZ + 999) / 1000);
  localparam logic [5:0] FSR_WP_CYC = 6'((FSR_T_WP_NS * FSR_CLK_MHZ + 999) / 1000);
  localparam logic [5:0] FSR_WPH_CYC = 6'((FSR_T_WEH_NS * FSR_CLK_MHZ + 999) / 1000);
  localparam logic [5:0] FSR_ACC_CYC = 6'((FSR_T_ACC_NS * FSR_CLK_MHZ + 999) / 1000);
  localparam logic [5:0] FSR_OEH_CYC = 6'((FSR_T_OEH_NS * FSR_CLK_MHZ + 999) / 1000);
  localparam logic [2:0] FSR_SEQ_NONE = 3'h0;

  typedef enum logic [2:0] {
    FSR_IDLE = 3'b000,
    FSR_SETUP = 3'b001,
    FSR_PULSE = 3'b010,
    FSR_HOLD = 3'b011,
    FSR_RDWAIT = 3'b100
  } fsr_phase_t;

  typedef struct packed {
    logic [26:0] adr;
    logic [15:0] dat;
    logic we;
  } fsr_op_t;

  typedef struct packed {
    logic [26:0] addr;
    logic [15:0] dq_out;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fsr_pins_t;

  typedef struct packed {
    fsr_phase_t phase;
    logic [5:0] cnt;
    logic [2:0] step;
    logic [2:0] seq;
    logic x8;
    logic die;
    logic hi_byte;
    fsr_op_t op;
    fsr_pins_t pins;
    logic [15:0] raw;
    logic [7:0] status;
    logic busy;
    logic done;
    logic cont_ok;
    logic cont_fail;
    logic [31:0] rdata;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
    logic [15:0] dq_s3;
  } fsr_state_t;
endpackage

// ===== rtl/fsr_host.sv
// host controller that issues reset, status and continuity sequences to a parallel flash
`timescale 1ns/10ps
module fsr_host
  import fsr_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // software register port
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // flash pins
  output logic [26:0] O_FL_ADDR,
  input wire logic [15:0] I_FL_DQ,
  output logic [15:0] O_FL_DQ,
  output logic O_FL_DQ_OE_N,
  output logic O_FL_CE_N,
  output logic O_FL_OE_N,
  output logic O_FL_WE_N
);
  fsr_state_t s_reg;
  fsr_state_t s_next;

  // sequences: 1 reset, 2 clear, 3 status read, 4 continuity check
  function automatic fsr_op_t seq_op(input logic [2:0] seq, input logic [2:0] step, input logic x8,
                                     input logic die, input logic hi);
    fsr_op_t o;
    logic [26:0] dsel;
    o = '{adr: 27'h0, dat: 16'h0, we: 1'b1};
    dsel = {die, 26'h0};
    unique case (seq)
      3'h1: o = '{adr: dsel, dat: FSR_CMD_RESET, we: 1'b1};
      3'h2: o = '{adr: dsel | FSR_ADR_555, dat: FSR_CMD_CLEAR, we: 1'b1};
      3'h3: begin
        if (step == 3'h0) begin
          o = '{adr: dsel | (x8 ? FSR_ADR_AAA : FSR_ADR_555), dat: FSR_CMD_STATUS, we: 1'b1};
        end else begin
          o = '{adr: dsel | {26'h0, hi}, dat: 16'h0, we: 1'b0};
        end
      end
      default: begin
        unique case (step)
          3'h0: o = '{adr: dsel | FSR_ADR_555, dat: FSR_CMD_CLEAR, we: 1'b1};
          3'h1: o = '{adr: dsel | (x8 ? FSR_ADR_AAA : FSR_ADR_555), dat: FSR_CMD_STATUS, we: 1'b1};
          3'h2: o = '{adr: dsel, dat: 16'h0, we: 1'b0};
          // pattern covers all address and data lines; die bit overrides top address
          3'h3: o = '{adr: {die, (x8 ? FSR_ADR_P1_X8[25:0] : FSR_ADR_P1_X16[25:0])},
                      dat: (x8 ? FSR_DAT_P1_X8 : FSR_DAT_P1), we: 1'b1};
          3'h4: o = '{adr: {die, (x8 ? FSR_ADR_P2_X8[25:0] : FSR_ADR_P2_X16[25:0])},
                      dat: (x8 ? FSR_DAT_P2_X8 : FSR_DAT_P2), we: 1'b1};
          3'h5: o = '{adr: dsel | (x8 ? FSR_ADR_AAA : FSR_ADR_555), dat: FSR_CMD_STATUS, we: 1'b1};
          default: o = '{adr: dsel, dat: 16'h0, we: 1'b0};
        endcase
      end
    endcase
    return o;
  endfunction

  function automatic logic [2:0] seq_len(input logic [2:0] seq);
    unique case (seq)
      3'h3: return 3'h2;
      3'h4: return 3'h7;
      default: return 3'h1;
    endcase
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.dq_s1 = I_FL_DQ;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.dq_s3 = s_reg.dq_s2;
    s_next.done = 1'b0;
    s_next.rdata = 32'h0;
    // ************************************************
    // software register port
    // ************************************************
    if (I_RD) begin
      unique case (I_ADDR)
        FSR_STAT_OFS: s_next.rdata = {28'h0, s_reg.cont_fail, s_reg.cont_ok, s_reg.done, s_reg.busy};
        FSR_RESULT_OFS: s_next.rdata = {24'h0, s_reg.status};
        FSR_RAW_OFS: s_next.rdata = {16'h0, s_reg.raw};
        default: s_next.rdata = 32'h0;
      endcase
    end
    if (I_WR && I_ADDR == FSR_CTRL_OFS && !s_reg.busy) begin
      s_next.x8 = I_WDATA[FSR_CMD_X8_BIT];
      s_next.die = I_WDATA[FSR_CMD_DIE_BIT];
      if (I_WDATA[FSR_CMD_CHECK_BIT]) s_next.seq = 3'h4;
      else if (I_WDATA[FSR_CMD_STATUS_BIT]) s_next.seq = 3'h3;
      else if (I_WDATA[FSR_CMD_CLEAR_BIT]) s_next.seq = 3'h2;
      else if (I_WDATA[FSR_CMD_RESET_BIT]) s_next.seq = 3'h1;
      else s_next.seq = FSR_SEQ_NONE;
      s_next.busy = (s_next.seq != FSR_SEQ_NONE);
      s_next.step = 3'h0;
      s_next.hi_byte = 1'b0;
      if (s_next.busy) s_next.cont_ok = 1'b0;
      if (s_next.busy) s_next.cont_fail = 1'b0;
    end
    // ************************************************
    // bus cycle engine
    // ************************************************
    unique case (s_reg.phase)
      FSR_IDLE: begin
        if (s_reg.busy) begin
          s_next.op = seq_op(s_reg.seq, s_reg.step, s_reg.x8, s_reg.die, s_reg.hi_byte);
          s_next.pins.addr = s_next.op.adr;
          s_next.pins.dq_out = s_next.op.dat;
          s_next.pins.dq_oe_n = !s_next.op.we;
          s_next.pins.ce_n = 1'b0;
          s_next.cnt = FSR_SETUP_CYC;
          s_next.phase = FSR_SETUP;
        end
      end
      FSR_SETUP: begin
        if (s_reg.cnt <= 6'h1) begin
          if (s_reg.op.we) begin
            s_next.pins.we_n = 1'b0;
            s_next.cnt = FSR_WP_CYC;
            s_next.phase = FSR_PULSE;
          end else begin
            s_next.pins.oe_n = 1'b0;
            s_next.cnt = FSR_ACC_CYC;
            s_next.phase = FSR_RDWAIT;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 6'h1;
        end
      end
      FSR_PULSE: begin
        if (s_reg.cnt <= 6'h1) begin
          s_next.pins.we_n = 1'b1;
          s_next.cnt = FSR_WPH_CYC;
          s_next.phase = FSR_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt - 6'h1;
        end
      end
      FSR_RDWAIT: begin
        // sample only once the last two synchroniser stages agree
        if (s_reg.cnt <= 6'h1 && s_reg.dq_s2 == s_reg.dq_s3) begin
          s_next.raw = s_reg.dq_s3;
          // in x8 the low byte comes first, then A0 toggles for the high byte
          if (s_reg.x8 && s_reg.seq == 3'h3 && !s_reg.hi_byte) begin
            s_next.status = s_reg.dq_s3[7:0] & FSR_STATUS_MASK;
            s_next.hi_byte = 1'b1;
            s_next.pins.addr = {s_reg.op.adr[26:1], 1'b1};
            s_next.op.adr = {s_reg.op.adr[26:1], 1'b1};
            s_next.cnt = FSR_ACC_CYC;
          end else begin
            if (!(s_reg.x8 && s_reg.seq == 3'h3)) begin
              s_next.status = s_reg.dq_s3[7:0] & FSR_STATUS_MASK;
            end
            if (s_reg.seq == 3'h4 && s_reg.step == 3'h2 && s_reg.dq_s3[FSR_CONT_BIT]) begin
              s_next.cont_fail = 1'b1;
            end
            if (s_reg.seq == 3'h4 && s_reg.step == 3'h6) begin
              s_next.cont_ok = s_reg.dq_s3[FSR_CONT_BIT] && !s_reg.cont_fail;
              s_next.cont_fail = s_reg.cont_fail || !s_reg.dq_s3[FSR_CONT_BIT];
            end
            s_next.pins.oe_n = 1'b1;
            s_next.cnt = FSR_OEH_CYC;
            s_next.phase = FSR_HOLD;
          end
        end else if (s_reg.cnt > 6'h1) begin
          s_next.cnt = s_reg.cnt - 6'h1;
        end
      end
      FSR_HOLD: begin
        if (s_reg.cnt <= 6'h1) begin
          s_next.pins.ce_n = 1'b1;
          s_next.pins.dq_oe_n = 1'b1;
          s_next.phase = FSR_IDLE;
          if (s_reg.step + 3'h1 >= seq_len(s_reg.seq)) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.seq = FSR_SEQ_NONE;
          end else begin
            s_next.step = s_reg.step + 3'h1;
          end
        end else begin
          s_next.cnt = s_reg.cnt - 6'h1;
        end
      end
      default: s_next.phase = FSR_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      s_reg <= '0;
      s_reg.phase <= FSR_IDLE;
      s_reg.pins.dq_oe_n <= 1'b1;
      s_reg.pins.ce_n <= 1'b1;
      s_reg.pins.oe_n <= 1'b1;
      s_reg.pins.we_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_RDATA = s_reg.rdata;
  assign O_FL_ADDR = s_reg.pins.addr;
  assign O_FL_DQ = s_reg.pins.dq_out;
  assign O_FL_DQ_OE_N = s_reg.pins.dq_oe_n;
  assign O_FL_CE_N = s_reg.pins.ce_n;
  assign O_FL_OE_N = s_reg.pins.oe_n;
  assign O_FL_WE_N = s_reg.pins.we_n;

  // ************************************************
  // checks
  // ************************************************
  sequence we_pulse_s;
    $fell(O_FL_WE_N) ##1 !O_FL_WE_N [*1];
  endsequence

  write_drive_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !O_FL_WE_N |-> !O_FL_DQ_OE_N && !O_FL_CE_N) else $error("write without data drive");
  strobe_excl_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !(!O_FL_WE_N && !O_FL_OE_N)) else $error("write and read strobes together");
  wph_gap_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $rose(O_FL_WE_N) |-> O_FL_WE_N [*5]) else $error("write high time too short");
  we_width_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    we_pulse_s |-> ##[1:8] O_FL_WE_N) else $error("write pulse too long");
  read_release_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $fell(O_FL_OE_N) |-> ##[1:60] O_FL_OE_N) else $error("read never ends");
  read_float_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !O_FL_OE_N |-> O_FL_DQ_OE_N) else $error("bus driven during read");
  cont_excl_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !(s_reg.cont_ok && s_reg.cont_fail)) else $error("continuity pass and fail");
  status_mask_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    I_RD && I_ADDR == FSR_RESULT_OFS |=> O_RDATA[31:8] == 24'h0) else $error("upper status not masked");
  die_pattern_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !O_FL_WE_N |-> O_FL_ADDR[FSR_DIE_BIT] == s_reg.die) else $error("wrong die selected");
endmodule // fsr_host

// ===== verif/fsr_flash_model.sv
// behavioural model of the flash status, reset and continuity logic
`timescale 1ns/10ps
module fsr_flash_model
  import fsr_pkg::*;
#(
  parameter logic DIE_ID = 1'b0
)
(
  // reset and test hooks
  input wire logic i_rst_n,
  input wire logic i_x8,
  input wire logic i_preset,
  input wire logic [7:0] i_preset_val,
  // flash pins
  input wire logic [26:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n
);
  logic [7:0] sts = 8'h80;
  logic ovl = 1'b0;
  logic [7:0] rd_cnt = 8'h00;
  logic [15:0] last_dq = 16'h0000;
  logic [15:0] drv;
  logic [26:0] prev_adr = 27'h0;
  logic [15:0] prev_dat = 16'h0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  logic pre_q = 1'b0;
  // ************************************************
  // read path
  // ************************************************
  always_comb begin
    if (ovl) begin
      drv = (i_x8 && i_addr[0]) ? {8'h00, rd_cnt} : {rd_cnt, sts};
    end else begin
      drv = ~i_addr[15:0];
    end
  end
  // released bus shows the inverse of the last value
  assign o_dq = (i_ce_n || i_oe_n) ? ~last_dq : drv;
  // ************************************************
  // command decode on strobe edges
  // ************************************************
  always @(i_we_n, i_oe_n, i_preset, i_rst_n) begin
    if (!i_rst_n) begin
      sts = 8'h80;
      ovl = 1'b0;
    end else if (i_preset && !pre_q) begin
      sts = i_preset_val;
    end else if (i_we_n && !we_q && !i_ce_n) begin
      if (i_dq[7:0] == 8'hf0) begin
        if (sts[FSR_READY_BIT]) begin
          ovl = 1'b0;
          if (!sts[3]) sts = sts & 8'hcc;
        end
      end else if (ovl) begin
        ovl = 1'b1;
      end else if (i_dq[7:0] == 8'h71 && i_addr[11:0] == 12'h555) begin
        sts = sts & 8'hc4;
      end else if (i_dq[7:0] == 8'h70 && (i_addr[11:0] == 12'h555 || i_addr[11:0] == 12'haaa)) begin
        ovl = 1'b1;
      end else if (i_addr[FSR_DIE_BIT] == DIE_ID && prev_adr[FSR_DIE_BIT] == DIE_ID
                   && (i_x8 ? (prev_dat[7:0] == 8'hff && i_dq[7:0] == 8'h00)
                            : (prev_dat == FSR_DAT_P1 && i_dq == FSR_DAT_P2))
                   && i_addr[25:0] == ~prev_adr[25:0]) begin
        sts[FSR_CONT_BIT] = 1'b1;
      end
      prev_adr = i_addr;
      prev_dat = i_dq;
    end else if (i_oe_n && !oe_q && !i_ce_n) begin
      last_dq = drv;
      ovl = 1'b0;
      rd_cnt = rd_cnt + 8'h01;
    end
    we_q = i_we_n;
    oe_q = i_oe_n;
    pre_q = i_preset;
  end
endmodule // fsr_flash_model

// ===== verif/flash_status_reset_continuity_tb.sv
// self-checking testbench of the flash status and continuity host
`timescale 1ns/10ps
module flash_status_reset_continuity_tb
  import fsr_pkg::*;
;
  logic clk, rst_n, wr, rd, x8, pre;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d, seed;
  logic [26:0] fl_addr;
  logic [15:0] fl_dq_in, fl_dq_out, mdl_dq;
  logic dq_oe_n, ce_n, oe_n, we_n;
  logic [7:0] pre_val, v;
  logic [31:0] cmd [4] = '{32'h4, 32'h14, 32'h2, 32'h1};
  int err_total = 0;
  int tests_run = 0;
  int m;
  assign fl_dq_in = dq_oe_n ? mdl_dq : fl_dq_out;
  fsr_host i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_FL_ADDR(fl_addr), .I_FL_DQ(fl_dq_in), .O_FL_DQ(fl_dq_out), .O_FL_DQ_OE_N(dq_oe_n),
    .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n));
  fsr_flash_model #(.DIE_ID(1'b0)) i_flash (.i_rst_n(rst_n), .i_x8(x8), .i_preset(pre), .i_preset_val(pre_val),
    .i_addr(fl_addr), .i_dq(fl_dq_in), .o_dq(mdl_dq), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n));
  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] exp_sts(input int md, input logic [7:0] sv);
    if (md == 2) return sv & 8'hc4;
    if (md == 3 && sv[7] && !sv[3]) return sv & 8'hcc;
    return sv;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] dv);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dv;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] dv);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 dv = rdata;
  endtask
  task automatic run_cmd(input logic [31:0] c);
    logic [31:0] s;
    int n;
    reg_wr(FSR_CTRL_OFS, c);
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 3000) begin
      reg_rd(FSR_STAT_OFS, s);
      n++;
    end
    chk(s & 32'h1, 32'h0);
  endtask
  task automatic preset(input logic [7:0] pv);
    @(posedge clk);
    pre_val <= pv;
    @(posedge clk);
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
  endtask
  task automatic complete_run;
    $display("tests %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ************************************************
  // clock, watchdog and tests
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #160000;
    err_total++;
    complete_run;
  end
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    x8 = 1'b0;
    pre = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    pre_val = 8'h00;
    seed = 32'hc2a010cf;
    repeat (16) @(posedge clk);
    #1 chk({28'h0, dq_oe_n, ce_n, oe_n, we_n}, 32'hf);
    @(posedge clk) rst_n <= 1'b1;
    reg_rd(4'h2, d);
    chk(d, 32'h0);
    reg_rd(FSR_STAT_OFS, d);
    chk(d, 32'h0);
    run_cmd(32'h4);
    reg_rd(FSR_RESULT_OFS, d);
    chk(d, 32'h80);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      m = i % 4;
      seed = xs(seed);
      v = seed[7:0] | 8'h80;
      if (m == 3) v[3] = i[2];
      if (m == 3 && i >= 8) v[7] = 1'b0;
      x8 <= (m == 1);
      preset(v);
      run_cmd(cmd[m] | (seed & 32'hffffffc0));
      if (m >= 2) run_cmd(32'h4);
      reg_rd(FSR_RESULT_OFS, d);
      chk(d, {24'h0, exp_sts(m, v)});
      if (m != 1) begin
        reg_rd(FSR_RAW_OFS, d);
        chk(d & 32'hffff00ff, {24'h0, exp_sts(m, v)});
      end
      $display("status test %0d done", i);
    end
    for (int k = 0; k < 4; k++) begin
      x8 <= k[0];
      preset(8'h80);
      run_cmd({26'h0, k[1], k[0], 4'h8});
      reg_rd(FSR_STAT_OFS, d);
      chk(d & 32'hc, k[1] ? 32'h8 : 32'h4);
      reg_rd(FSR_RESULT_OFS, d);
      chk(d, k[1] ? 32'h80 : 32'h81);
      $display("continuity test %0d done", k);
    end
    complete_run;
  end
endmodule // flash_status_reset_continuity_tb
